// File: pkg/lamp_pkg.sv
// Constants shared by the fault lamp blink code controller.
`default_nettype none
package lamp_pkg;
   // =========================================================
   // Timebase
   localparam int CLK_HZ       = 25_000_000;
   localparam int TICK_MS      = 100;
   localparam int TICK_CYCLES  = CLK_HZ / 1000 * TICK_MS;
   // =========================================================
   // Flash timing, in milliseconds and in ticks
   localparam int LONG_ON_MS   = 600;
   localparam int SHORT_ON_MS  = 300;
   localparam int DIGIT_GAP_MS = 1000;
   localparam int CODE_GAP_MS  = 1800;
   localparam logic [4:0] LONG_TICKS   = 5'(LONG_ON_MS / TICK_MS);
   localparam logic [4:0] SHORT_TICKS  = 5'(SHORT_ON_MS / TICK_MS);
   localparam logic [4:0] DGAP_TICKS   = 5'(DIGIT_GAP_MS / TICK_MS);
   localparam logic [4:0] CGAP_TICKS   = 5'(CODE_GAP_MS / TICK_MS);
   // =========================================================
   // Pedal gesture timing
   localparam int SETTLE_MS    = 3000;
   localparam int PUMP_MS      = 5000;
   localparam int PAUSE_MS     = 7000;
   localparam int HOLD_MS      = 10000;
   localparam logic [7:0] SETTLE_TICKS = 8'(SETTLE_MS / TICK_MS);
   localparam logic [7:0] PUMP_TICKS   = 8'(PUMP_MS / TICK_MS);
   localparam logic [7:0] PAUSE_TICKS  = 8'(PAUSE_MS / TICK_MS);
   localparam logic [7:0] HOLD_TICKS   = 8'(HOLD_MS / TICK_MS);
   localparam logic [2:0] PUMP_COUNT   = 3'd5;
   // =========================================================
   // Fault handling
   localparam logic [2:0] FAILSAFE_TRIPS = 3'd5;
   localparam logic [13:0] RPM_CEILING   = 14'd2500;
   localparam logic [3:0] ZERO_FLASHES   = 4'ha;
   localparam logic [15:0] NO_FAULT_CODE = 16'h0000;
   localparam int CODE_DEPTH             = 8;
   // =========================================================
   // State types
   typedef enum {G_IDLE, G_SETTLE, G_PUMP, G_PAUSE, G_HOLD, G_RESULTS, G_ERASED, G_BLOCKED} gesture_t;
   typedef enum {D_ON, D_OFF, D_GAP} flash_t;
endpackage : lamp_pkg
`default_nettype wire

// File: hdl/fault_lamp_blink_code_controller.sv
// Fault warning lamp controller with pedal-entered blink code display.
// Behaviour
// - Lamp test at key-on until engine runs.
// - Light lamp on two-trip or one-trip faults.
// - Fail-safe after five consecutive failing trips.
// - Fail-safe also on direct throttle-controller failure while the lamp circuit is not open.
// - Fail-safe cuts fuel at or above 2500 rpm.
// - Pedal sensor fault blocks mode change.
// - Ignition off returns to warning mode.
// - Readiness blink shown further 10s during hold.
// - Pedal release after hold enters results mode.
// - Results hold over 10s erases stored codes.
// - After erase and release, show code 0000.
// - Confirmed and first-trip codes shown together.
// - Stored code list repeats continuously.
// - Four digits, MSD first, zero is ten.
// - Thousands flash 0.6s on, 0.6s off.
// - Lower digit flash 0.3s on, 0.3s off.
// - Extra 1.0s off between digits.
// - Extra 1.8s off between codes.
`default_nettype none
module fault_lamp_blink_code_controller #(
   parameter int TICK_CYCLES = lamp_pkg::TICK_CYCLES,
   parameter int CODE_DEPTH  = lamp_pkg::CODE_DEPTH
) (
   input  wire logic        ref_clk_i,
   input  wire logic        arst_n_i,
   input  wire logic        ignition_on_i,
   input  wire logic        engine_running_i,
   input  wire logic        pedal_full_i,
   input  wire logic        pedal_released_i,
   input  wire logic        pedal_sensor_fault_i,
   input  wire logic        trip_done_i,
   input  wire logic        trip_fault_i,
   input  wire logic        one_trip_fault_i,
   input  wire logic        misfire_i,
   input  wire logic        throttle_ctrl_fail_i,
   input  wire logic        lamp_circuit_open_i,
   input  wire logic        readiness_incomplete_i,
   input  wire logic        code_wr_i,
   input  wire logic [15:0] code_i,
   input  wire logic [13:0] engine_rpm_i,
   output logic             fault_warning_lamp_o,
   output logic             fuel_cut_o,
   output logic             failsafe_o,
   output logic             results_mode_o,
   output logic             erase_o
);

   // =========================================================
   // Reset release and pin synchronisers
   logic [1:0] rst_pipe;
   logic       rst_n;
   logic [3:0] pin_s1;
   logic [3:0] pin_s2;
   logic [3:0] pin_s3;
   logic [3:0] pin;
   logic       ign;
   logic       eng;
   logic       ped_full;
   logic       ped_rel;

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_pipe <= 2'h0;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end
   assign rst_n = rst_pipe[1];

   // A pin level is taken only once two later stages agree, so a glitch is filtered.
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1 <= 4'h0;
         pin_s2 <= 4'h0;
         pin_s3 <= 4'h0;
         pin    <= 4'h0;
      end else begin
         pin_s1 <= {ignition_on_i, engine_running_i, pedal_full_i, pedal_released_i};
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
         for (int i = 0; i < 4; i++) begin
            if (pin_s2[i] == pin_s3[i]) begin
               pin[i] <= pin_s3[i];
            end
         end
      end
   end
   assign ign      = pin[3];
   assign eng      = pin[2];
   assign ped_full = pin[1];
   assign ped_rel  = pin[0];

   // =========================================================
   // Timebase
   logic [21:0] tick_cnt;
   logic        tick;

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt <= 22'h0;
         tick     <= 1'b0;
      end else if (tick_cnt == 22'(TICK_CYCLES - 1)) begin
         tick_cnt <= 22'h0;
         tick     <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 22'h1;
         tick     <= 1'b0;
      end
   end

   // =========================================================
   // Trip detection and fail-safe
   logic       prev_trip_fault;
   logic       confirmed;
   logic [2:0] fail_trips;
   logic       failsafe;
   logic       erase_now;
   localparam logic [2:0] FAILSAFE_TRIPS_L = lamp_pkg::FAILSAFE_TRIPS;

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         prev_trip_fault <= 1'b0;
         confirmed       <= 1'b0;
      end else if (trip_done_i) begin
         prev_trip_fault <= trip_fault_i;
         if (trip_fault_i && prev_trip_fault) begin
            confirmed <= 1'b1;
         end else if (erase_now) begin
            confirmed <= 1'b0;
         end
      end else if (erase_now) begin
         confirmed       <= 1'b0;
         prev_trip_fault <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         fail_trips <= 3'h0;
         failsafe   <= 1'b0;
      end else begin
         if (trip_done_i) begin
            fail_trips <= throttle_ctrl_fail_i ? ((fail_trips == FAILSAFE_TRIPS_L) ? fail_trips : fail_trips + 3'h1)
                                               : 3'h0;
         end
         if (trip_done_i && throttle_ctrl_fail_i && fail_trips == FAILSAFE_TRIPS_L - 3'h1) begin
            failsafe <= 1'b1;
         end
         if (throttle_ctrl_fail_i && !lamp_circuit_open_i) begin
            failsafe <= 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         fuel_cut_o <= 1'b0;
         failsafe_o <= 1'b0;
      end else begin
         failsafe_o <= failsafe;
         fuel_cut_o <= failsafe && (engine_rpm_i >= lamp_pkg::RPM_CEILING);
      end
   end

   // =========================================================
   // Stored code list
   logic [15:0] codes [CODE_DEPTH];
   logic [3:0]  code_cnt;

   always_ff @(posedge ref_clk_i) begin
      if (code_wr_i && code_cnt < 4'(CODE_DEPTH)) begin
         codes[code_cnt[2:0]] <= code_i;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         code_cnt <= 4'h0;
      end else if (erase_now) begin
         code_cnt <= 4'h0;
      end else if (code_wr_i && code_cnt < 4'(CODE_DEPTH)) begin
         code_cnt <= code_cnt + 4'h1;
      end
   end

   // =========================================================
   // Pedal gesture and mode control
   lamp_pkg::gesture_t gst;
   logic [7:0] gtime;
   logic [2:0] pumps;
   logic       pumped_down;
   logic       readiness_show;

   assign erase_now = (gst == lamp_pkg::G_RESULTS) && tick && ped_full && (gtime == lamp_pkg::HOLD_TICKS);
   assign readiness_show = (gst == lamp_pkg::G_HOLD) && readiness_incomplete_i && (gtime >= lamp_pkg::HOLD_TICKS);

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         gst         <= lamp_pkg::G_IDLE;
         gtime       <= 8'h0;
         pumps       <= 3'h0;
         pumped_down <= 1'b0;
      end else if (!ign) begin
         gst         <= lamp_pkg::G_IDLE;
         gtime       <= 8'h0;
         pumps       <= 3'h0;
         pumped_down <= 1'b0;
      end else if (pedal_sensor_fault_i && gst != lamp_pkg::G_RESULTS && gst != lamp_pkg::G_ERASED) begin
         gst <= lamp_pkg::G_BLOCKED;
      end else begin
         if (tick && gtime != 8'hff) begin
            gtime <= gtime + 8'h1;
         end
         unique case (gst)
            lamp_pkg::G_IDLE: begin
               gtime <= 8'h0;
               gst   <= ped_rel ? lamp_pkg::G_SETTLE : lamp_pkg::G_BLOCKED;
            end
            lamp_pkg::G_SETTLE: begin
               if (!ped_rel) begin
                  gst <= (gtime >= lamp_pkg::SETTLE_TICKS && ped_full) ? lamp_pkg::G_PUMP : lamp_pkg::G_BLOCKED;
                  gtime       <= 8'h0;
                  pumped_down <= 1'b1;
               end
            end
            lamp_pkg::G_PUMP: begin
               if (gtime > lamp_pkg::PUMP_TICKS) begin
                  gst <= lamp_pkg::G_BLOCKED;
               end else if (ped_full && !pumped_down) begin
                  pumped_down <= 1'b1;
               end else if (ped_rel && pumped_down) begin
                  pumped_down <= 1'b0;
                  pumps       <= pumps + 3'h1;
                  if (pumps == lamp_pkg::PUMP_COUNT - 3'h1) begin
                     gst   <= lamp_pkg::G_PAUSE;
                     gtime <= 8'h0;
                  end
               end
            end
            lamp_pkg::G_PAUSE: begin
               if (ped_full) begin
                  gst   <= (gtime >= lamp_pkg::PAUSE_TICKS) ? lamp_pkg::G_HOLD : lamp_pkg::G_BLOCKED;
                  gtime <= 8'h0;
               end
            end
            lamp_pkg::G_HOLD: begin
               if (!ped_full) begin
                  if (ped_rel && gtime >= (readiness_incomplete_i ? 8'(2 * lamp_pkg::HOLD_TICKS)
                                                                  : lamp_pkg::HOLD_TICKS)) begin
                     gst <= lamp_pkg::G_RESULTS;
                  end else begin
                     gst <= lamp_pkg::G_BLOCKED;
                  end
                  gtime <= 8'h0;
               end
            end
            lamp_pkg::G_RESULTS: begin
               if (!ped_full) begin
                  gtime <= 8'h0;
               end else if (erase_now) begin
                  gst <= lamp_pkg::G_ERASED;
               end
            end
            lamp_pkg::G_ERASED: begin
               gtime <= 8'h0;
               if (ped_rel) begin
                  gst <= lamp_pkg::G_RESULTS;
               end
            end
            lamp_pkg::G_BLOCKED: begin
               gtime <= 8'h0;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         erase_o        <= 1'b0;
         results_mode_o <= 1'b0;
      end else begin
         erase_o        <= erase_now;
         results_mode_o <= (gst == lamp_pkg::G_RESULTS) || (gst == lamp_pkg::G_ERASED);
      end
   end

   // =========================================================
   // Blink code sequencer
   lamp_pkg::flash_t fst;
   logic [4:0]  ftime;
   logic [1:0]  digit;
   logic [3:0]  flashes;
   logic [2:0]  code_idx;
   logic [15:0] cur_code;
   logic [3:0]  digit_val;
   logic [3:0]  digit_flashes;
   logic [4:0]  on_ticks;
   logic        showing;

   assign cur_code  = (code_cnt == 4'h0) ? lamp_pkg::NO_FAULT_CODE : codes[code_idx];
   assign digit_val = cur_code[4'(12 - 4 * digit) +: 4];
   // value sets flash count, zero gives ten.
   assign digit_flashes = (digit_val == 4'h0) ? lamp_pkg::ZERO_FLASHES : digit_val;
   assign on_ticks = (digit == 2'h0) ? lamp_pkg::LONG_TICKS : lamp_pkg::SHORT_TICKS;
   assign showing  = (gst == lamp_pkg::G_RESULTS) && !ped_full;

   // one list for both code kinds.
   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         fst      <= lamp_pkg::D_ON;
         ftime    <= 5'h0;
         digit    <= 2'h0;
         flashes  <= 4'h1;
         code_idx <= 3'h0;
      end else if (!showing) begin
         fst      <= lamp_pkg::D_ON;
         ftime    <= 5'h0;
         digit    <= 2'h0;
         flashes  <= 4'h1;
         code_idx <= 3'h0;
      end else if (tick) begin
         ftime <= ftime + 5'h1;
         unique case (fst)
            lamp_pkg::D_ON: begin
               if (ftime == on_ticks - 5'h1) begin
                  fst   <= lamp_pkg::D_OFF;
                  ftime <= 5'h0;
               end
            end
            lamp_pkg::D_OFF: begin
               if (ftime == on_ticks - 5'h1) begin
                  ftime <= 5'h0;
                  if (flashes == digit_flashes) begin
                     fst <= lamp_pkg::D_GAP;
                  end else begin
                     fst     <= lamp_pkg::D_ON;
                     flashes <= flashes + 4'h1;
                  end
               end
            end
            lamp_pkg::D_GAP: begin
               if (ftime == ((digit == 2'h3) ? lamp_pkg::CGAP_TICKS : lamp_pkg::DGAP_TICKS) - 5'h1) begin
                  fst     <= lamp_pkg::D_ON;
                  ftime   <= 5'h0;
                  flashes <= 4'h1;
                  digit   <= digit + 2'h1;
                  if (digit == 2'h3) begin
                     code_idx <= (4'(code_idx) + 4'h1 >= code_cnt) ? 3'h0 : code_idx + 3'h1;
                  end
               end
            end
         endcase
      end
   end

   // =========================================================
   // Lamp driver
   logic blink_phase;

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         blink_phase <= 1'b0;
      end else if (tick) begin
         blink_phase <= ~blink_phase;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         fault_warning_lamp_o <= 1'b0;
      end else if (!ign) begin
         fault_warning_lamp_o <= 1'b0;
      end else if (showing) begin
         fault_warning_lamp_o <= (fst == lamp_pkg::D_ON);
      end else if (readiness_show) begin
         fault_warning_lamp_o <= blink_phase;
      end else if (!eng) begin
         fault_warning_lamp_o <= 1'b1;
      end else if (misfire_i) begin
         fault_warning_lamp_o <= blink_phase;
      end else begin
         fault_warning_lamp_o <= confirmed || one_trip_fault_i;
      end
   end

endmodule : fault_lamp_blink_code_controller
`default_nettype wire

// File: bench/lamp_checker.sv
// Port-level assertions for the fault lamp blink code controller.
`default_nettype none
module lamp_checker #(
   parameter int TICK_CYCLES = 4,
   parameter int CODE_DEPTH  = 8
) (
   input wire logic        ref_clk_i,
   input wire logic        arst_n_i,
   input wire logic        ignition_on_i,
   input wire logic        engine_running_i,
   input wire logic        pedal_full_i,
   input wire logic        pedal_released_i,
   input wire logic        pedal_sensor_fault_i,
   input wire logic        trip_done_i,
   input wire logic        trip_fault_i,
   input wire logic        one_trip_fault_i,
   input wire logic        misfire_i,
   input wire logic        throttle_ctrl_fail_i,
   input wire logic        lamp_circuit_open_i,
   input wire logic        readiness_incomplete_i,
   input wire logic        code_wr_i,
   input wire logic [15:0] code_i,
   input wire logic [13:0] engine_rpm_i,
   input wire logic        fault_warning_lamp_o,
   input wire logic        fuel_cut_o,
   input wire logic        failsafe_o,
   input wire logic        results_mode_o,
   input wire logic        erase_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   // Assertions
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!arst_n_i);
   property p_cut_on;
      (failsafe_o && engine_rpm_i >= lamp_pkg::RPM_CEILING) [*2] |-> fuel_cut_o;
   endproperty
   a_cut_on: assert property (p_cut_on) else $error("fuel not cut above ceiling");
   property p_cut_off;
      (engine_rpm_i < lamp_pkg::RPM_CEILING) [*2] |-> !fuel_cut_o;
   endproperty
   a_cut_off: assert property (p_cut_off) else $error("fuel cut below ceiling");
   property p_fs_enter;
      throttle_ctrl_fail_i && !lamp_circuit_open_i |-> ##[1:6] failsafe_o;
   endproperty
   a_fs_enter: assert property (p_fs_enter) else $error("failsafe not entered");
   property p_fs_hold;
      failsafe_o |=> failsafe_o;
   endproperty
   a_fs_hold: assert property (p_fs_hold) else $error("failsafe dropped");
   property p_key_off;
      (!ignition_on_i) [*8] |-> !results_mode_o && !fault_warning_lamp_o;
   endproperty
   a_key_off: assert property (p_key_off) else $error("mode kept after key off");
   property p_erase;
      erase_o |-> results_mode_o ##1 !erase_o;
   endproperty
   a_erase: assert property (p_erase) else $error("erase pulse outside results");
   property p_enter;
      $rose(results_mode_o) |-> !pedal_full_i && ignition_on_i;
   endproperty
   a_enter: assert property (p_enter) else $error("results entered without release");
   property p_refuse;
      pedal_sensor_fault_i [*3] |-> !$rose(results_mode_o);
   endproperty
   a_refuse: assert property (p_refuse) else $error("mode changed with sensor fault");
   property p_bulb;
      (ignition_on_i && !engine_running_i && !results_mode_o && pedal_released_i) [*8] |-> fault_warning_lamp_o;
   endproperty
   a_bulb: assert property (p_bulb) else $error("lamp test missing");
   property p_one_trip;
      (engine_running_i && one_trip_fault_i && !misfire_i && !results_mode_o) [*6] |-> fault_warning_lamp_o;
   endproperty
   a_one_trip: assert property (p_one_trip) else $error("one-trip lamp missing");
endmodule : lamp_checker
bind fault_lamp_blink_code_controller lamp_checker #(.TICK_CYCLES(TICK_CYCLES), .CODE_DEPTH(CODE_DEPTH)) chk_u (
   .ref_clk_i, .arst_n_i, .ignition_on_i, .engine_running_i, .pedal_full_i, .pedal_released_i,
   .pedal_sensor_fault_i, .trip_done_i, .trip_fault_i, .one_trip_fault_i, .misfire_i, .throttle_ctrl_fail_i,
   .lamp_circuit_open_i, .readiness_incomplete_i, .code_wr_i, .code_i, .engine_rpm_i,
   .fault_warning_lamp_o, .fuel_cut_o, .failsafe_o, .results_mode_o, .erase_o);
`default_nettype wire

// File: bench/operator_model.sv
// Behavioural operator at the ignition key and the accelerator pedal.
`default_nettype none
module operator_model #(
   parameter int TC = 4
) (
   input  wire logic ref_clk_i,
   output logic      ignition_on_o,
   output logic      pedal_full_o,
   output logic      pedal_released_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      ignition_on_o    = 1'h0;
      pedal_full_o     = 1'h0;
      pedal_released_o = 1'h1;
   end
   task automatic ticks(input int n);
      repeat (n * TC) @(posedge ref_clk_i);
      #2;
   endtask : ticks
   // The two pedal switches never report full and released at once.
   task automatic pedal(input logic down);
      pedal_full_o     = down;
      pedal_released_o = ~down;
   endtask : pedal
   task automatic key(input logic on);
      ignition_on_o = on;
   endtask : key
   task automatic gesture(input int settle, input int hold);
      pedal(1'h0);
      key(1'h1);
      ticks(settle);
      repeat (5) begin
         pedal(1'h1);
         ticks(2);
         pedal(1'h0);
         ticks(2);
      end
      ticks(75);
      pedal(1'h1);
      ticks(hold);
      pedal(1'h0);
   endtask : gesture
endmodule : operator_model
`default_nettype wire

// File: bench/tb_fault_lamp_blink_code_controller.sv
// Self-checking bench for the fault lamp blink code controller.
`default_nettype none
module tb_fault_lamp_blink_code_controller;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TC = 4;
   typedef struct packed {
      logic [13:0] rpm;
      logic        cut;
   } row_t;
   row_t        rows [5] = '{'{14'h0000, 1'h0}, '{lamp_pkg::RPM_CEILING - 14'h0001, 1'h0},
                             '{lamp_pkg::RPM_CEILING, 1'h1}, '{14'h3fff, 1'h1}, '{14'h0001, 1'h0}};
   logic        ref_clk_i = 1'h0, arst_n_i = 1'h0, seen;
   logic        ignition_on_i, pedal_full_i, pedal_released_i;
   logic        engine_running_i, pedal_sensor_fault_i, trip_done_i;
   logic        trip_fault_i, one_trip_fault_i, misfire_i, throttle_ctrl_fail_i;
   logic        lamp_circuit_open_i, readiness_incomplete_i, code_wr_i;
   logic [15:0] code_i;
   logic [13:0] engine_rpm_i;
   logic        fault_warning_lamp_o, fuel_cut_o, failsafe_o, results_mode_o, erase_o;
   int          n_fail = 0, comparisons = 0, n;
   int          exp_q [$];
   always #20 ref_clk_i = ~ref_clk_i;
   fault_lamp_blink_code_controller #(.TICK_CYCLES(TC), .CODE_DEPTH(8)) dut_u (
      .ref_clk_i, .arst_n_i, .ignition_on_i, .engine_running_i, .pedal_full_i, .pedal_released_i,
      .pedal_sensor_fault_i, .trip_done_i, .trip_fault_i, .one_trip_fault_i, .misfire_i, .throttle_ctrl_fail_i,
      .lamp_circuit_open_i, .readiness_incomplete_i, .code_wr_i, .code_i, .engine_rpm_i,
      .fault_warning_lamp_o, .fuel_cut_o, .failsafe_o, .results_mode_o, .erase_o);
   operator_model #(.TC(TC)) op_u (.ref_clk_i(ref_clk_i), .ignition_on_o(ignition_on_i),
      .pedal_full_o(pedal_full_i), .pedal_released_o(pedal_released_i));
   // ==========================================================
   // Helpers
   task automatic cyc(input int k);
      repeat (k) @(posedge ref_clk_i);
      #2;
   endtask : cyc
   task automatic chk(input logic got, input logic exp, input string what);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t %s", $time, what);
      end
   endtask : chk
   task automatic trip();
      trip_done_i = 1'h1;
      cyc(1);
      trip_done_i = 1'h0;
   endtask : trip
   task automatic wrap_up();
      $display("Counts: %0d compared, %0d bad", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : wrap_up
   // Expected lamp run lengths in ticks for one pass of a code, on first.
   function automatic void build(input logic [15:0] c);
      int cnt, on;
      exp_q = {};
      for (int d = 3; d >= 0; d--) begin
         cnt = (c[d*4 +: 4] == 4'h0) ? int'(lamp_pkg::ZERO_FLASHES) : int'(c[d*4 +: 4]);
         on = (d == 3) ? int'(lamp_pkg::LONG_TICKS) : int'(lamp_pkg::SHORT_TICKS);
         for (int k = 1; k <= cnt; k++) begin
            exp_q.push_back(on);
            exp_q.push_back(k < cnt ? on : on + (d == 0 ? int'(lamp_pkg::CGAP_TICKS) : int'(lamp_pkg::DGAP_TICKS)));
         end
      end
   endfunction : build
   // Aligns on the long gap that closes a pass, so a display already under way is no problem.
   task automatic show(input logic [15:0] c);
      int run;
      build(c);
      run = 0;
      for (int w = 0; w < 4000 && run < int'(lamp_pkg::CGAP_TICKS) * TC; w++) begin
         @(negedge ref_clk_i);
         run = (fault_warning_lamp_o === 1'h0) ? run + 1 : 0;
      end
      while (fault_warning_lamp_o !== 1'h1 && run < 4000) begin
         @(negedge ref_clk_i);
         run++;
      end
      exp_q.push_back(exp_q[0]);
      foreach (exp_q[i]) begin
         run = 0;
         while (fault_warning_lamp_o === logic'(i % 2 == 0) && run < 1000) begin
            @(negedge ref_clk_i);
            run++;
         end
         chk(logic'(run == exp_q[i] * TC), 1'h1, "flash run length");
      end
      cyc(1);
   endtask : show
   // ==========================================================
   // Tests
   initial begin
      {engine_running_i, pedal_sensor_fault_i, trip_done_i, trip_fault_i, one_trip_fault_i, misfire_i} = 6'h00;
      {throttle_ctrl_fail_i, lamp_circuit_open_i, readiness_incomplete_i, code_wr_i, code_i, engine_rpm_i} = 34'h0;
      cyc(8);
      arst_n_i = 1'h1;
      chk(fault_warning_lamp_o | fuel_cut_o | failsafe_o | results_mode_o | erase_o, 1'h0, "outputs at reset");
      $display("test reset done");
      throttle_ctrl_fail_i = 1'h1;
      cyc(8);
      chk(failsafe_o, 1'h1, "failsafe on fault");
      throttle_ctrl_fail_i = 1'h0;
      foreach (rows[i]) begin
         engine_rpm_i = rows[i].rpm;
         cyc(3);
         chk(fuel_cut_o, rows[i].cut, "fuel cut");
      end
      $display("test failsafe done");
      arst_n_i = 1'h0;
      engine_rpm_i = 14'h0000;
      cyc(2);
      chk(failsafe_o, 1'h0, "failsafe after reset");
      arst_n_i = 1'h1;
      op_u.key(1'h1);
      cyc(10);
      chk(fault_warning_lamp_o, 1'h1, "lamp test");
      engine_running_i = 1'h1;
      cyc(10);
      chk(fault_warning_lamp_o, 1'h0, "lamp off running");
      one_trip_fault_i = 1'h1;
      cyc(8);
      chk(fault_warning_lamp_o, 1'h1, "one-trip lamp");
      one_trip_fault_i = 1'h0;
      misfire_i = 1'h1;
      cyc(8);
      seen = fault_warning_lamp_o;
      cyc(TC);
      chk(fault_warning_lamp_o ^ seen, 1'h1, "misfire blink");
      misfire_i = 1'h0;
      $display("test warning done");
      op_u.key(1'h0);
      engine_running_i = 1'h0;
      code_i = 16'h1204;
      code_wr_i = 1'h1;
      cyc(1);
      code_wr_i = 1'h0;
      cyc(10);
      chk(fault_warning_lamp_o, 1'h0, "lamp off at key off");
      op_u.gesture(35, 110);
      cyc(10);
      chk(results_mode_o, 1'h1, "results entered");
      show(16'h1204);
      $display("test display done");
      op_u.pedal(1'h1);
      for (n = 0; n < 200 * TC && erase_o !== 1'h1; n++)
         cyc(1);
      chk(logic'(n >= (int'(lamp_pkg::HOLD_TICKS) - 1) * TC && n <= (int'(lamp_pkg::HOLD_TICKS) + 3) * TC), 1'h1,
          "erase hold time");
      op_u.pedal(1'h0);
      show(lamp_pkg::NO_FAULT_CODE);
      $display("test erase done");
      op_u.key(1'h0);
      cyc(10);
      chk(results_mode_o, 1'h0, "key off leaves results");
      pedal_sensor_fault_i = 1'h1;
      op_u.gesture(35, 110);
      cyc(10);
      chk(results_mode_o, 1'h0, "mode change refused");
      pedal_sensor_fault_i = 1'h0;
      op_u.key(1'h0);
      cyc(10);
      $display("test refusal done");
      readiness_incomplete_i = 1'h1;
      op_u.gesture(35, 110);
      cyc(10);
      chk(results_mode_o, 1'h0, "short hold refused");
      op_u.key(1'h0);
      cyc(10);
      op_u.gesture(35, 210);
      cyc(10);
      chk(results_mode_o, 1'h1, "long hold accepted");
      op_u.key(1'h0);
      readiness_incomplete_i = 1'h0;
      cyc(10);
      $display("test readiness done");
      op_u.key(1'h1);
      engine_running_i = 1'h1;
      trip_fault_i = 1'h1;
      cyc(10);
      trip();
      cyc(8);
      chk(fault_warning_lamp_o, 1'h0, "no lamp after one trip");
      trip();
      cyc(8);
      chk(fault_warning_lamp_o, 1'h1, "lamp after two trips");
      $display("test two-trip done");
      lamp_circuit_open_i = 1'h1;
      throttle_ctrl_fail_i = 1'h1;
      repeat (4) begin
         trip();
         cyc(1);
      end
      chk(failsafe_o, 1'h0, "no failsafe after four trips");
      trip();
      cyc(3);
      chk(failsafe_o, 1'h1, "failsafe after five trips");
      $display("test five-trip done");
      wrap_up();
   end
   initial begin
      repeat (40000) @(posedge ref_clk_i);
      n_fail++;
      $display("BAD t=%0t watchdog expired", $time);
      wrap_up();
   end
endmodule : tb_fault_lamp_blink_code_controller
`default_nettype wire
